// file: inc/awp_pkg.sv
// Shared constants and types for the arbitrary waveform player channel.
// Assumes a 20 MHz register clock and a waveform pool outside this block.
package awp_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] OFS_CTRL       = 8'h00;  // Pattern, origins, repeat, software trigger.
  localparam logic [7:0] OFS_TICK_RATE  = 8'h04;  // Own tick rate in Hz.
  localparam logic [7:0] OFS_GAIN       = 8'h08;  // Output gain, unsigned 16 bit.
  localparam logic [7:0] OFS_BASE_PHASE = 8'h0C;  // Static base phase, 65536 codes per 720 degCA.
  localparam logic [7:0] OFS_RUN_PHASE  = 8'h10;  // Runtime phase offset, signed 16 bit.
  localparam logic [7:0] OFS_SLEW       = 8'h14;  // Phase slew rate in degCA per second.
  localparam logic [7:0] OFS_STATUS     = 8'h18;  // Read-only playback status.
  localparam logic [7:0] OFS_SAMPLE     = 8'h1C;  // Read-only current address and output.

  // Field positions inside the control register.
  localparam int CTRL_PAT_LSB     = 0;   // Four bits of pattern selection.
  localparam int CTRL_ORIGIN_BIT  = 4;   // Tick origin select.
  localparam int CTRL_REPEAT_BIT  = 5;   // Playback repeat select.
  localparam int CTRL_START_LSB   = 8;   // Three bits of start origin.
  localparam int CTRL_SWTRIG_BIT  = 12;  // Software trigger level.

  // Values after reset.
  localparam logic [3:0]  RST_PATTERN      = 4'h0;
  localparam logic [2:0]  RST_START_ORIGIN = 3'h6;
  localparam logic [15:0] RST_GAIN         = 16'h0000;
  localparam logic [19:0] RST_TICK_RATE    = 20'h0_0000;
  localparam logic [9:0]  RST_SLEW         = 10'h000;

  // Encodings and limits.
  localparam logic [3:0]  PATTERN_MAX   = 4'hB;        // Twelve stored waveforms.
  localparam logic [2:0]  START_SW      = 3'h6;        // Software start origin.
  localparam logic [4:0]  SIZE_LOG2_MIN = 5'h04;       // 16 points.
  localparam logic [4:0]  SIZE_LOG2_MAX = 5'h10;       // 65536 points.
  localparam logic [15:0] GAIN_FULL     = 16'hFFFF;    // Gain of exactly one.
  localparam logic signed [15:0] SAMPLE_ONE = 16'sh4000; // +1.0 in two integer bits.

  // Clock and rate figures.
  localparam logic [24:0] CLK_HZ        = 25'h131_2D00; // 20 MHz register clock.
  localparam logic [19:0] LOCAL_MAX_HZ  = 20'hF_4240;   // 1 MHz ceiling of the own tick.
  localparam logic [9:0]  SLEW_MAX      = 10'h3E8;      // 1000 degCA per second.
  localparam int          HALF_TURN_DEG = 360;          // Half of the phase span in degCA.
  localparam int          HALF_TURN_LSB = 32768;        // Codes per 360 degCA.
  // One phase code per this many rate units accumulated each clock.
  localparam logic [33:0] SLEW_THRESH   = 34'(64'(HALF_TURN_DEG) * 64'(CLK_HZ));

  // Local playback states, Gray coded along idle to run.
  typedef enum logic [1:0] {
    PB_IDLE = 2'b00,
    PB_RUN  = 2'b01
  } pb_state_t;

endpackage

// file: src/phase_slewer.sv
// Moves the actual phase one code at a time toward the runtime target.
// Assumes target and rate come from registers on the same clock.
`timescale 1ns/1ps
module phase_slewer (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               ce,
  input  wire logic signed [15:0] target,
  input  wire logic        [9:0]  rate,
  output logic signed      [15:0] actual
);
  import awp_pkg::*;

  // All state of the slewer in one record.
  typedef struct packed {
    logic        [33:0] acc;     // Accumulated rate times codes per half turn.
    logic signed [15:0] actual;  // Phase actually applied.
  } slew_state_t;

  slew_state_t q, d;
  logic [9:0]  rate_lim;         // Rate clamped to the ceiling.
  logic [33:0] acc_sum;          // Accumulator after this clock's increment.

  // Next state: build up credit at the programmed rate, spend it per code.
  always_comb begin
    d        = q;
    rate_lim = (rate > SLEW_MAX) ? SLEW_MAX : rate;
    acc_sum  = q.acc + (34'(rate_lim) << 15);
    if (q.actual == target) begin
      // Nothing to move, so no credit is kept for later.
      d.acc = 34'h0_0000_0000;
    end else begin
      // A zero rate never builds credit, so the phase stays where it is. RULE9
      d.acc = acc_sum;
      if (acc_sum >= SLEW_THRESH) begin
        d.acc = acc_sum - SLEW_THRESH;
        if (q.actual < target) begin
          d.actual = q.actual + 16'sh0001; // RULE9
        end else begin
          d.actual = q.actual - 16'sh0001; // RULE9
        end
      end
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign actual = q.actual;

endmodule // phase_slewer

// file: src/wave_player.sv
// One channel of the arbitrary waveform player with its APB register file.
// Assumes a synchronous waveform pool answering pool_addr one clock later,
// and an engine-speed clock and trigger pins from outside the clock domain.
//
// Notes on behaviour
// RULE1: play the pattern selected, values 0 to 11
// RULE2: origin 0 engine clock, 1 own tick
// RULE3: own rate used locally, at most 1 MHz
// RULE4: gain 0 is zero, 65535 is one
// RULE5: output only samples within plus/minus one
// RULE6: effective phase is base plus runtime offset
// RULE7: host keeps base phase within 720 degCA
// RULE8: runtime offset signed, full range plus/minus 360
// RULE9: actual phase slews toward target at rate
// RULE10: host sets nonzero slew rate normally
// RULE11: repeat 0 endless, 1 single pass
// RULE12: effective phase sets local start point
// RULE13: always play the full stored point count
// RULE14: rising trigger starts local playback
// RULE15: every rising trigger restarts from start point
// RULE16: start origin 0-5 external, 6 software
// RULE17: external start needs nonzero own rate
// RULE18: engine clock advances on both edges
// RULE19: host stores power of two sizes 16-65536
// RULE20: local playback idle until first trigger
`timescale 1ns/1ps
module wave_player #(
  parameter int ADDR_W = 8  // APB address width.
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               ce,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               speed_clk,
  input  wire logic [5:0]         ext_trig,
  output logic      [3:0]         pool_sel,
  output logic      [15:0]        pool_addr,
  input  wire logic signed [15:0] pool_data,
  input  wire logic [4:0]         pool_size_log2,
  output logic signed [15:0]      wave_out,
  output logic                    out_range_err,
  output logic                    playing
);
  import awp_pkg::*;

  // Every flip-flop of the channel outside the slewer.
  typedef struct packed {
    logic [3:0]         pattern;     // Pattern selection.
    logic               origin;      // Tick origin select.
    logic               repeat_one;  // Playback repeat select.
    logic [2:0]         start_orig;  // Start origin.
    logic               sw_trig;     // Software trigger level.
    logic [19:0]        tick_rate;   // Own tick rate in Hz.
    logic [15:0]        gain;        // Output gain.
    logic [15:0]        base_phase;  // Base phase offset.
    logic [15:0]        run_phase;   // Runtime phase offset target.
    logic [9:0]         slew;        // Phase slew rate.
    logic               spd_s1;      // Engine clock, first synchroniser stage.
    logic               spd_s2;      // Engine clock, second stage.
    logic               spd_prev;    // Engine clock, previous synchronised level.
    logic [5:0]         trig_s1;     // Trigger pins, first stage.
    logic [5:0]         trig_s2;     // Trigger pins, second stage.
    logic               trig_prev;   // Selected trigger, previous level.
    pb_state_t          pb_state;    // Local playback state.
    logic [24:0]        nco;         // Own tick phase accumulator.
    logic [15:0]        index;       // Point index before the phase shift.
    logic [16:0]        count;       // Points played in this local pass.
    logic [3:0]         pool_sel;    // Registered pool selection.
    logic [15:0]        pool_addr;   // Registered pool address.
    logic signed [15:0] wave_out;    // Registered output sample.
    logic               range_err;   // Last sample lay outside plus/minus one.
    logic               playing;     // Output is live.
    logic               pready;      // APB ready.
    logic               pslverr;     // APB error.
    logic [31:0]        prdata;      // APB read data.
  } chan_state_t;

  chan_state_t q, d;

  logic signed [15:0] actual_phase;  // Slewed runtime offset.
  logic [15:0]        eff_phase;     // Base plus slewed offset.
  logic [4:0]         size_log2;     // Point count exponent, clamped.
  logic [15:0]        size_mask;     // Point count minus one.
  logic [15:0]        phase_pts;     // Effective phase in points.
  logic [19:0]        rate_lim;      // Own rate clamped to the ceiling.
  logic [24:0]        nco_sum;       // Accumulator after this clock.
  logic               local_tick;    // Own tick this clock.
  logic               speed_tick;    // Engine clock edge this clock.
  logic               trig_level;    // Selected trigger level.
  logic               trig_rise;     // Selected trigger rose.
  logic [32:0]        product;       // Sample times gain.
  logic signed [15:0] scaled;        // Sample after gain.
  logic               in_range;      // Sample within plus/minus one.
  logic               access;        // APB access phase.
  logic               mapped;        // Address hits a register.
  logic [7:0]         reg_ofs;       // Address bits that select a register.
  logic [31:0]        rd_word;       // Read data for the current address.

  // Runtime phase slews toward its target instead of jumping.
  phase_slewer u_slewer (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .target  (q.run_phase),
    .rate    (q.slew),
    .actual  (actual_phase)
  );

  // Next state of the whole channel.
  always_comb begin
    d = q;

    // Two-stage synchronisers for the pins; only the second stage is read.
    d.spd_s1   = speed_clk;
    d.spd_s2   = q.spd_s1;
    d.spd_prev = q.spd_s2;
    d.trig_s1  = ext_trig;
    d.trig_s2  = q.trig_s1;

    // Either edge of the engine clock moves one point. RULE18
    speed_tick = q.spd_s2 ^ q.spd_prev;

    // Offset codes wrap modulo 65536, one turn of 720 degCA. RULE6 RULE8
    eff_phase = q.base_phase + actual_phase;

    // Exponent kept in the legal range so the mask is always sane.
    if (pool_size_log2 < SIZE_LOG2_MIN) begin
      size_log2 = SIZE_LOG2_MIN;
    end else if (pool_size_log2 > SIZE_LOG2_MAX) begin
      size_log2 = SIZE_LOG2_MAX;
    end else begin
      size_log2 = pool_size_log2;
    end
    size_mask = 16'((17'h1_0000 >> (5'h10 - size_log2)) - 17'h0_0001);
    phase_pts = eff_phase >> (5'h10 - size_log2);

    // Own tick generator, rate clamped to 1 MHz. RULE3
    rate_lim   = (q.tick_rate > LOCAL_MAX_HZ) ? LOCAL_MAX_HZ : q.tick_rate;
    nco_sum    = q.nco + 25'(rate_lim);
    local_tick = 1'b0;
    if (q.origin && q.pb_state == PB_RUN) begin
      // The rate only counts while the own tick is selected. RULE3
      d.nco = nco_sum;
      if (nco_sum >= CLK_HZ) begin
        d.nco      = nco_sum - CLK_HZ;
        local_tick = 1'b1;
      end
    end

    // Start origin chooses a pin or the software bit. RULE16
    if (q.start_orig == START_SW) begin
      trig_level = q.sw_trig;
    end else if (q.start_orig < START_SW) begin
      trig_level = q.trig_s2[q.start_orig];
    end else begin
      trig_level = 1'b0;
    end
    trig_rise   = trig_level && !q.trig_prev;
    d.trig_prev = trig_level;

    // Playback sequencing.
    if (!q.origin) begin
      // Engine clock drives the index freely. RULE2
      if (speed_tick) begin
        d.index = (q.index + 16'h0001) & size_mask;
      end
    end else begin
      unique case (q.pb_state)
        PB_IDLE: begin
          // Held until a trigger edge arrives. RULE20 RULE14
          if (trig_rise) begin
            d.pb_state = PB_RUN;
            d.index    = 16'h0000;
            d.count    = 17'h0_0000;
            d.nco      = 25'h000_0000;
          end
        end
        PB_RUN: begin
          if (trig_rise) begin
            // Any rising edge restarts, finished pass or not. RULE15
            d.index = 16'h0000;
            d.count = 17'h0_0000;
            d.nco   = 25'h000_0000;
          end else if (local_tick) begin
            // A pass is the full stored point count. RULE13 RULE11
            if (q.repeat_one && q.count == {1'b0, size_mask}) begin
              d.pb_state = PB_IDLE;
            end else begin
              d.index = (q.index + 16'h0001) & size_mask;
              d.count = (q.count == {1'b0, size_mask}) ? 17'h0_0000
                                                        : q.count + 17'h0_0001;
            end
          end
        end
      endcase
    end

    // The phase shifts the start point in both modes. RULE12
    d.pool_addr = (q.index + phase_pts) & size_mask;
    // Only codes 0 to 11 reach the pool. RULE1
    d.pool_sel  = (q.pattern > PATTERN_MAX) ? PATTERN_MAX : q.pattern;
    d.playing   = !q.origin || (q.pb_state == PB_RUN);

    // Gain as a fraction of 65536, with full code 65535 passing exactly. RULE4
    product = 33'($signed(pool_data) * $signed({1'b0, q.gain}));
    scaled  = (q.gain == GAIN_FULL) ? pool_data : product[31:16];
    // Samples beyond plus/minus one give no output. RULE5
    in_range    = (pool_data <= SAMPLE_ONE) && (pool_data >= -SAMPLE_ONE);
    d.range_err = q.playing && !in_range;
    d.wave_out  = (q.playing && in_range) ? scaled : 16'sh0000;

    // APB slave: ready comes from a flip-flop set in the setup cycle.
    reg_ofs = 8'(paddr);
    access  = psel && penable && q.pready;
    unique case (reg_ofs)
      OFS_CTRL, OFS_TICK_RATE, OFS_GAIN, OFS_BASE_PHASE,
      OFS_RUN_PHASE, OFS_SLEW, OFS_STATUS, OFS_SAMPLE: mapped = 1'b1;
      default:                                          mapped = 1'b0;
    endcase
    if (ADDR_W > 8 && (paddr >> 8) != '0) begin
      mapped = 1'b0;
    end
    unique case (reg_ofs)
      OFS_CTRL:       rd_word = {19'h0_0000, q.sw_trig, 1'b0, q.start_orig,
                                 2'h0, q.repeat_one, q.origin, q.pattern};
      OFS_TICK_RATE:  rd_word = {12'h000, q.tick_rate};
      OFS_GAIN:       rd_word = {16'h0000, q.gain};
      OFS_BASE_PHASE: rd_word = {16'h0000, q.base_phase};
      OFS_RUN_PHASE:  rd_word = {16'h0000, q.run_phase};
      OFS_SLEW:       rd_word = {22'h00_0000, q.slew};
      OFS_STATUS:     rd_word = {actual_phase, 13'h0000, q.range_err,
                                 q.pb_state == PB_RUN, q.playing};
      OFS_SAMPLE:     rd_word = {q.pool_addr, q.wave_out};
      default:        rd_word = 32'h0000_0000;
    endcase

    // Answer in the first cycle of the access phase, then drop.
    d.pready  = psel && !penable;
    d.pslverr = psel && !penable && !mapped;
    if (psel && !penable) begin
      d.prdata = mapped && !pwrite ? rd_word : 32'h0000_0000;
    end

    // Register writes take effect at the end of the access phase.
    if (access && pwrite && mapped) begin
      unique case (reg_ofs)
        OFS_CTRL: begin
          d.pattern    = pwdata[CTRL_PAT_LSB +: 4];
          d.origin     = pwdata[CTRL_ORIGIN_BIT];
          d.repeat_one = pwdata[CTRL_REPEAT_BIT];
          d.start_orig = pwdata[CTRL_START_LSB +: 3];
          d.sw_trig    = pwdata[CTRL_SWTRIG_BIT];
        end
        OFS_TICK_RATE:  d.tick_rate  = pwdata[19:0];
        OFS_GAIN:       d.gain       = pwdata[15:0];
        OFS_BASE_PHASE: d.base_phase = pwdata[15:0];
        OFS_RUN_PHASE:  d.run_phase  = pwdata[15:0];
        OFS_SLEW:       d.slew       = pwdata[9:0];
        default:        d.slew       = q.slew;
      endcase
    end
  end

  // Channel state register, frozen while the clock enable is low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q            <= '0;
      q.pattern    <= RST_PATTERN;
      q.start_orig <= RST_START_ORIGIN;
      q.gain       <= RST_GAIN;
      q.tick_rate  <= RST_TICK_RATE;
      q.slew       <= RST_SLEW;
      q.pb_state   <= PB_IDLE;
    end else if (ce) begin
      q <= d;
    end
  end

  // Outputs straight from the state register.
  assign prdata        = q.prdata;
  assign pready        = q.pready;
  assign pslverr       = q.pslverr;
  assign pool_sel      = q.pool_sel;
  assign pool_addr     = q.pool_addr;
  assign wave_out      = q.wave_out;
  assign out_range_err = q.range_err;
  assign playing       = q.playing;

endmodule // wave_player

// file: tb/pool_model.sv
// Waveform pool model standing at the far side of the player channel.
// Assumes one clock shared with the player and a read latency of one clock.
`timescale 1ns/1ps
module pool_model (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [3:0]         pool_sel,
  input  wire logic [15:0]        pool_addr,
  output logic signed [15:0]      pool_data,
  output logic        [4:0]       pool_size_log2
);
  // Every stored table holds 16 points, a power of two.
  assign pool_size_log2 = 5'h04;
  // Reads answer one clock late; table 11 is deliberately out of range.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pool_data <= 16'h0000;
    end else if (pool_sel == 4'hB) begin
      pool_data <= 16'h7FFF;
    end else begin
      pool_data <= {2'b00, pool_sel, pool_addr[9:0]};
    end
  end
endmodule  // pool_model

// file: tb/wave_player_monitor.sv
// Port checker for the player channel.
// Assumes it is bound into every instance of the player.
`timescale 1ns/1ps
module wave_player_monitor #(
  parameter int ADDR_W = 8  // APB address width.
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               ce,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [ADDR_W-1:0]  paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               speed_clk,
  input wire logic [5:0]         ext_trig,
  input wire logic [3:0]         pool_sel,
  input wire logic [15:0]        pool_addr,
  input wire logic signed [15:0] pool_data,
  input wire logic [4:0]         pool_size_log2,
  input wire logic signed [15:0] wave_out,
  input wire logic               out_range_err,
  input wire logic               playing
);
  // All checks share the register clock and its reset.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_ready_setup: assert property (ce && psel && !penable && !pready |=> pready)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_sel_range: assert property (pool_sel <= 4'hB)
    else $error("pool_sel beyond last table");
  a_range_zero: assert property (out_range_err |-> wave_out == 16'h0000)
    else $error("output while sample out of range");
  a_err_play: assert property (out_range_err |-> playing)
    else $error("range error while not playing");
  a_idle_zero: assert property (!playing [*3] |-> wave_out == 16'h0000)
    else $error("output while idle");
  a_addr_size: assert property (playing && $stable(pool_size_log2)
    |-> 17'(pool_addr) < (17'h0_0001 << pool_size_log2))
    else $error("pool_addr beyond table size");
endmodule  // wave_player_monitor

bind wave_player wave_player_monitor #(.ADDR_W(ADDR_W)) i_wave_player_monitor (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .speed_clk(speed_clk), .ext_trig(ext_trig),
  .pool_sel(pool_sel), .pool_addr(pool_addr), .pool_data(pool_data),
  .pool_size_log2(pool_size_log2), .wave_out(wave_out),
  .out_range_err(out_range_err), .playing(playing));

// file: tb/tb_wave_player.sv
// Self-checking bench for the player channel with a pool model.
// Assumes the APB answer and register map given in the package.
`timescale 1ns/1ps
module tb_wave_player;
  import awp_pkg::*;
  logic               pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic               speed_clk, out_range_err, playing, rerr;
  logic        [7:0]  paddr;
  logic        [31:0] pwdata, prdata, rdata;
  logic        [5:0]  ext_trig;
  logic        [3:0]  pool_sel;
  logic        [15:0] pool_addr;
  logic signed [15:0] pool_data, wave_out;
  logic        [4:0]  pool_size_log2;
  int                 num_errors, checks, cycles;

  wave_player #(.ADDR_W(8)) i_wave_player (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .speed_clk(speed_clk),
    .ext_trig(ext_trig), .pool_sel(pool_sel), .pool_addr(pool_addr),
    .pool_data(pool_data), .pool_size_log2(pool_size_log2), .wave_out(wave_out),
    .out_range_err(out_range_err), .playing(playing));
  pool_model i_pool_model (.pclk(pclk), .presetn(presetn), .pool_sel(pool_sel),
    .pool_addr(pool_addr), .pool_data(pool_data), .pool_size_log2(pool_size_log2));

  // Free-running 20 MHz clock.
  always #25 pclk = ~pclk;

  // Compares a seen value against the expected one and counts both outcomes.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; holds the request until pready is sampled high.
  // An idle cycle follows, so back-to-back calls never drive psel twice at one edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Each toggle of the engine clock is one point; the wait covers the synchroniser.
  task automatic edges(input int n);
    repeat (n) begin
      speed_clk <= ~speed_clk;
      wt(8);
    end
  endtask

  // Reset values and a refused address.
  task automatic t_regs;
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    chk("ctrl reset", rdata, 32'h0000_0600);
    apb(1'b0, OFS_GAIN, 32'h0000_0000);
    chk("gain reset", rdata, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped err", 32'(rerr), 32'h0000_0001);
    chk("unmapped data", rdata, 32'h0000_0000);
    $display("test regs done");
  endtask

  // Engine clock advances one point per edge of either polarity, wrapping at 16.
  task automatic t_engine;
    apb(1'b1, OFS_CTRL, 32'h0000_0005);
    edges(5);
    chk("pool_sel", 32'(pool_sel), 32'h0000_0005);
    chk("addr five", 32'(pool_addr), 32'h0000_0005);
    edges(14);
    chk("addr wrap", 32'(pool_addr), 32'h0000_0003);
    chk("playing", 32'(playing), 32'h0000_0001);
    $display("test engine done");
  endtask

  // Gain of zero, one half and one on sample 0x1403.
  task automatic t_gain;
    logic [15:0] g[3];
    logic [15:0] e[3];
    g = '{16'h0000, 16'h8000, 16'hFFFF};
    e = '{16'h0000, 16'h0A01, 16'h1403};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFS_GAIN, 32'(g[i]));
      wt(4);
      chk("wave_out", 32'(wave_out), 32'(e[i]));
    end
    $display("test gain done");
  endtask

  // A sample beyond plus one gives no output and flags the error.
  task automatic t_range;
    apb(1'b1, OFS_CTRL, 32'h0000_000B);
    edges(1);
    chk("err set", 32'(out_range_err), 32'h0000_0001);
    chk("out blocked", 32'(wave_out), 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_0005);
    edges(1);
    chk("err clear", 32'(out_range_err), 32'h0000_0000);
    $display("test range done");
  endtask

  // Clock enable low freezes the index and the synchronisers; the edge lands later.
  task automatic t_hold;
    ce <= 1'b0;
    edges(1);
    chk("frozen", 32'(pool_addr), 32'h0000_0005);
    ce <= 1'b1;
    wt(8);
    chk("thawed", 32'(pool_addr), 32'h0000_0006);
    $display("test hold done");
  endtask

  // Own tick at 1 MHz, single pass of 16 points started by software.
  task automatic t_single;
    apb(1'b1, OFS_TICK_RATE, 32'h000F_4240);
    apb(1'b1, OFS_CTRL, 32'h0000_0635);
    wt(4);
    chk("idle", 32'(playing), 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_1635);
    wt(3);
    chk("started", 32'(playing), 32'h0000_0001);
    chk("first point", 32'(pool_addr), 32'h0000_0000);
    wt(200);
    chk("mid pass", 32'(playing), 32'h0000_0001);
    wt(200);
    chk("pass over", 32'(playing), 32'h0000_0000);
    $display("test single done");
  endtask

  // External start on pin 3 only.
  task automatic t_ext;
    apb(1'b1, OFS_CTRL, 32'h0000_0335);
    ext_trig <= 6'h04;
    wt(10);
    chk("other pin", 32'(playing), 32'h0000_0000);
    ext_trig <= 6'h08;
    wt(10);
    chk("pin three", 32'(playing), 32'h0000_0001);
    ext_trig <= 6'h00;
    $display("test ext done");
  endtask

  // Continuous run from a shifted start, then a restart mid-run.
  task automatic t_cont;
    apb(1'b1, OFS_BASE_PHASE, 32'h0000_2000);
    apb(1'b1, OFS_CTRL, 32'h0000_0615);
    apb(1'b1, OFS_CTRL, 32'h0000_1615);
    wt(3);
    chk("start", 32'(pool_addr), 32'h0000_0002);
    wt(500);
    chk("endless", 32'(playing), 32'h0000_0001);
    apb(1'b1, OFS_CTRL, 32'h0000_0615);
    apb(1'b1, OFS_CTRL, 32'h0000_1615);
    wt(3);
    chk("restart", 32'(pool_addr), 32'h0000_0002);
    $display("test cont done");
  endtask

  // Runtime offset moves about one code per 220 cycles at 1000 degCA/s.
  task automatic t_slew;
    apb(1'b1, OFS_SLEW, 32'h0000_03E8);
    apb(1'b1, OFS_RUN_PHASE, 32'h0000_0004);
    wt(300);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("slewing", 32'(rdata[31:16]), 32'h0000_0001);
    wt(900);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("slewed", 32'(rdata[31:16]), 32'h0000_0004);
    apb(1'b1, OFS_RUN_PHASE, 32'h0000_FFFC);
    wt(2200);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("negative", 32'(rdata[31:16]), 32'h0000_FFFC);
    $display("test slew done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  // Reset for 20 cycles, then run the scenarios in order.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    speed_clk = 1'b0;
    ext_trig = 6'h00;
    wt(20);
    presetn <= 1'b1;
    wt(1);
    t_regs();
    t_engine();
    t_gain();
    t_range();
    t_hold();
    t_single();
    t_ext();
    wt(400);
    t_cont();
    t_slew();
    finish_test();
  end
endmodule  // tb_wave_player
